//--- hdl/ipmc_ctrl.sv
// interrupt request, mask, priority and in-service control with watchdog mode write path
`timescale 1ns/1ps

// Operation
// R1 - a set request flag is a pending request; clear means none
// R2 - a set mask flag blocks acknowledgment, vectored and macro service alike
// R3 - a clear mask flag lets the source be acknowledged
// R4 - service-kind bit set selects macro service, clear selects vectored or swap
// R5 - outside macro service, bank-swap bit set selects context switching
// R6 - level field 00 is highest through 11 lowest
// R7 - block mask bits and control-byte mask bits are one storage
// R8 - mask word reachable as word, bytes and bits; upper byte as byte and bits
// R9 - reset sets mask word to all ones and upper mask byte to all ones
// R10 - acknowledging a maskable request sets the in-service bit of its level; the code sets none for a macro service ack
// R11 - acknowledging the watchdog non-maskable request sets in-service bit 6
// R12 - vectored or swap return clears only the highest-priority set in-service bit
// R13 - break returns leave the in-service register unchanged
// R14 - reset clears the in-service register
// R15 - software never writes the in-service register
// R16 - nest block bit set forbids level 3 nesting; clear allows it
// R17 - reset sets the nesting mode control register to 80h
// R18 - software disables interrupts before changing nesting mode control
// R19 - watchdog mode written only by checked immediate write; mismatch raises operand error
// R20 - operand error return address is the faulting instruction's start address
// R21 - any other write to watchdog mode is silently ignored
// R22 - watchdog mode readable any time and cleared by reset
// R23 - operand error handlers should reinitialise rather than break-return
// R24 - acknowledging a request clears its request flag
// R25 - control byte: request 7, mask 6, kind 5, swap 4, level 1:0, resets 43h
// R26 - present the highest-level pending unmasked request that may nest now
module ipmc_ctrl
  import ipmc_pkg::*;
(
  input  logic             clk_sys_i,         // system clock
  input  logic             reset_i,           // synchronous reset, active high
  input  logic [15:0]      sfr_addr_i,        // register address
  input  logic             sfr_wr_i,          // register write strobe
  input  logic             sfr_rd_i,          // register read strobe
  input  ipmc_acc_t        sfr_size_i,        // byte, word or bit access
  input  logic [2:0]       sfr_bit_i,         // bit number for bit access
  input  logic [15:0]      sfr_wdata_i,       // write data, bit access uses bit 0
  output logic [15:0]      sfr_rdata_o,       // read data, one cycle after read
  input  logic [NSRC-1:0]  src_req_i,         // peripheral request pulses
  input  logic             wdog_req_i,        // watchdog non-maskable request pulse
  input  logic             cpu_ack_i,         // cpu takes the presented request
  input  logic             nmi_ack_i,         // cpu takes the non-maskable request
  input  logic             vec_ret_i,         // vectored return executed
  input  logic             swap_ret_i,        // bank-swap return executed
  input  logic             brk_ret_i,         // break return executed
  input  logic             swap_brk_ret_i,    // bank-swap break return executed
  input  logic             wdm_imm_wr_i,      // checked immediate write to watchdog mode
  input  logic [7:0]       wdm_imm_data_i,    // third byte, the value
  input  logic [7:0]       wdm_imm_check_i,   // fourth byte, its complement
  input  logic [PC_W-1:0]  instr_addr_i,      // start address of current instruction
  output logic             intr_req_o,        // maskable request presented
  output logic [SRC_W-1:0] intr_src_o,        // presented source
  output logic [1:0]       intr_level_o,      // presented level
  output ipmc_kind_t       intr_kind_o,       // vectored, swap or macro service
  output logic             nmi_req_o,         // non-maskable request pending
  output logic             operr_req_o,       // operand error interrupt pulse
  output logic [PC_W-1:0]  operr_ret_addr_o   // return address to push
);

  // ==========================================================================
  // storage
  logic [NSRC-1:0]   request_pending_flag;
  logic [NSRC-1:0]   service_kind_select;
  logic [NSRC-1:0]   bank_swap_select;
  logic [2*NSRC-1:0] level_field;
  logic [MASK_W-1:0] mask_bits;
  logic [7:0]        in_service_level;
  logic [7:0]        next_in_service;
  logic              lowest_level_nest_block;
  logic [7:0]        watchdog_mode;
  logic              nmi_pend;

  logic [NSRC-1:0]   source_block_flag;
  logic [15:0]       source_mask_word;
  logic [7:0]        source_mask_byte_upper;
  assign source_block_flag      = mask_bits[NSRC-1:0];   // [R7]
  assign source_mask_word       = mask_bits[15:0];
  assign source_mask_byte_upper = mask_bits[23:16];

  // ==========================================================================
  // byte write decode: returns {enable, new value} for the byte at address a
  function automatic logic [8:0] upd(input logic [7:0] old, input logic [15:0] a);
    logic [7:0] v;
    v   = old;
    upd = {1'b0, old};
    if (sfr_wr_i)
    begin
      case (sfr_size_i)
        IPMC_ACC_WORD:
          if (!sfr_addr_i[0] && a[15:1] == sfr_addr_i[15:1])
            upd = {1'b1, a[0] ? sfr_wdata_i[15:8] : sfr_wdata_i[7:0]};
        IPMC_ACC_BIT:
          if (a == sfr_addr_i)
          begin
            v[sfr_bit_i] = sfr_wdata_i[0];
            upd          = {1'b1, v};
          end
        default:
          if (a == sfr_addr_i)
            upd = {1'b1, sfr_wdata_i[7:0]};
      endcase
    end
  endfunction

  // ==========================================================================
  // per-source control bytes
  logic [7:0]        ctl_rd  [NSRC];
  logic [8:0]        ctl_upd [NSRC];
  logic [MASK_W-1:0] ctl_mask_en;
  logic [MASK_W-1:0] ctl_mask_val;
  logic [NSRC-1:0]   ack_hit;

  genvar gi;
  for (gi = 0; gi < NSRC; gi++)
  begin : g_src
    assign ctl_rd[gi] = {request_pending_flag[gi], source_block_flag[gi], service_kind_select[gi],
                         bank_swap_select[gi], 2'b00, level_field[2*gi +: 2]};   // [R25]
    assign ctl_upd[gi] = upd(ctl_rd[gi], ADDR_CTRL_BASE + 16'(gi));
    assign ctl_mask_en[gi]  = ctl_upd[gi][8];
    assign ctl_mask_val[gi] = ctl_upd[gi][CTL_MASK_BIT];
    assign ack_hit[gi] = cpu_ack_i && intr_req_o && intr_src_o == SRC_W'(gi);

    // a request arriving with a clear still sets the flag
    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
        request_pending_flag[gi] <= CTL_RESET[CTL_REQ_BIT];
      else if (src_req_i[gi])
        request_pending_flag[gi] <= 1'b1;                                   // [R1]
      else if (ack_hit[gi])
        request_pending_flag[gi] <= 1'b0;                                   // [R24]
      else if (ctl_upd[gi][8])
        request_pending_flag[gi] <= ctl_upd[gi][CTL_REQ_BIT];
    end

    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
      begin
        service_kind_select[gi]  <= CTL_RESET[CTL_KIND_BIT];
        bank_swap_select[gi]     <= CTL_RESET[CTL_SWAP_BIT];
        level_field[2*gi +: 2]   <= CTL_RESET[1:0];
      end
      else if (ctl_upd[gi][8])
      begin
        service_kind_select[gi]  <= ctl_upd[gi][CTL_KIND_BIT];
        bank_swap_select[gi]     <= ctl_upd[gi][CTL_SWAP_BIT];
        level_field[2*gi +: 2]   <= ctl_upd[gi][1:0];
      end
    end
  end

  genvar gx;
  for (gx = NSRC; gx < MASK_W; gx++)
  begin : g_nosrc
    assign ctl_mask_en[gx]  = 1'b0;
    assign ctl_mask_val[gx] = 1'b0;
  end

  // ==========================================================================
  // block mask registers share the mask storage with the control bytes
  logic [8:0] mlo_upd;
  logic [8:0] mhi_upd;
  logic [8:0] mup_upd;
  assign mlo_upd = upd(source_mask_word[7:0], ADDR_MASK_WORD_LO);    // [R8]
  assign mhi_upd = upd(source_mask_word[15:8], ADDR_MASK_WORD_HI);
  assign mup_upd = upd(source_mask_byte_upper, ADDR_MASK_UPPER);

  genvar gm;
  for (gm = 0; gm < MASK_W; gm++)
  begin : g_mask
    logic [8:0] bu;
    assign bu = (gm < 8) ? mlo_upd : (gm < 16) ? mhi_upd : mup_upd;
    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
        mask_bits[gm] <= (gm < 16) ? MASK_WORD_RESET[gm % 16] : MASK_UPPER_RESET[gm % 8]; // [R9]
      else if (ctl_mask_en[gm])
        mask_bits[gm] <= ctl_mask_val[gm];                                  // [R7]
      else if (bu[8])
        mask_bits[gm] <= bu[gm % 8];
    end
  end

  // ==========================================================================
  // nesting mode control
  logic [8:0] nest_upd;
  assign nest_upd = upd({lowest_level_nest_block, 7'h00}, ADDR_NEST_CTRL);

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      lowest_level_nest_block <= NEST_CTRL_RESET[NEST_BIT];                 // [R17]
    else if (nest_upd[8])
      lowest_level_nest_block <= nest_upd[NEST_BIT];
  end

  // ==========================================================================
  // arbitration and presentation
  logic [NSRC-1:0]  res_pend;
  logic             res_valid;
  logic [SRC_W-1:0] res_src;
  logic [1:0]       res_level;
  ipmc_kind_t       res_kind;

  assign res_pend = request_pending_flag & ~source_block_flag;              // [R2] [R3]

  ipmc_resolver u_resolver (
    .pend_i       (res_pend),
    .level_i      (level_field),
    .in_service_i (in_service_level[3:0]),
    .nmi_busy_i   (in_service_level[NMI_BIT]),
    .nest_block_i (lowest_level_nest_block),
    .valid_o      (res_valid),
    .src_o        (res_src),
    .level_o      (res_level)
  );

  always_comb
  begin
    if (service_kind_select[res_src])
      res_kind = IPMC_KIND_MACRO;                                           // [R4]
    else if (bank_swap_select[res_src])
      res_kind = IPMC_KIND_SWAP;                                            // [R5]
    else
      res_kind = IPMC_KIND_VECTOR;
  end

  // dropped for one cycle after an ack so the taken source is not offered twice
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      intr_req_o   <= 1'b0;
      intr_src_o   <= '0;
      intr_level_o <= LEVEL_LOWEST;
      intr_kind_o  <= IPMC_KIND_VECTOR;
    end
    else
    begin
      intr_req_o   <= res_valid && !cpu_ack_i;                              // [R26]
      intr_src_o   <= res_src;
      intr_level_o <= res_level;
      intr_kind_o  <= res_kind;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      nmi_pend <= 1'b0;
    else if (wdog_req_i)
      nmi_pend <= 1'b1;
    else if (nmi_ack_i)
      nmi_pend <= 1'b0;
  end
  assign nmi_req_o = nmi_pend;

  // ==========================================================================
  // in-service register, never written by software
  always_comb
  begin
    logic done;
    done            = 1'b0;
    next_in_service = in_service_level;
    if (vec_ret_i || swap_ret_i)                                            // [R12] [R13]
    begin
      if (in_service_level[NMI_BIT])
      begin
        next_in_service[NMI_BIT] = 1'b0;
        done                     = 1'b1;
      end
      for (int l = 0; l < 4; l++)
      begin
        if (!done && in_service_level[l])
        begin
          next_in_service[l] = 1'b0;
          done               = 1'b1;
        end
      end
    end
    if (cpu_ack_i && intr_req_o && intr_kind_o != IPMC_KIND_MACRO)
      next_in_service[intr_level_o] = 1'b1;                                 // [R10]
    if (nmi_ack_i)
      next_in_service[NMI_BIT] = 1'b1;                                      // [R11]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      in_service_level <= IN_SERVICE_RESET;                                 // [R14]
    else
      in_service_level <= next_in_service;
  end

  // ==========================================================================
  // watchdog mode: only the checked immediate write lands; bus writes are dropped
  logic wdm_ok;
  assign wdm_ok = wdm_imm_data_i == ~wdm_imm_check_i;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      watchdog_mode <= WDOG_MODE_RESET;                                     // [R22]
    else if (wdm_imm_wr_i && wdm_ok)
      watchdog_mode <= wdm_imm_data_i & WDOG_MODE_WMASK;                    // [R19] [R21]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      operr_req_o      <= 1'b0;
      operr_ret_addr_o <= '0;
    end
    else
    begin
      operr_req_o <= wdm_imm_wr_i && !wdm_ok;                               // [R19]
      if (wdm_imm_wr_i && !wdm_ok)
        operr_ret_addr_o <= instr_addr_i;                                   // [R20]
    end
  end

  // ==========================================================================
  // register read
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    logic [15:0] off;
    off = a - ADDR_CTRL_BASE;
    case (a)
      ADDR_IN_SERVICE:   byte_at = in_service_level;
      ADDR_NEST_CTRL:    byte_at = {lowest_level_nest_block, 7'h00};
      ADDR_MASK_WORD_LO: byte_at = source_mask_word[7:0];
      ADDR_MASK_WORD_HI: byte_at = source_mask_word[15:8];
      ADDR_MASK_UPPER:   byte_at = source_mask_byte_upper;
      ADDR_WDOG_MODE:    byte_at = watchdog_mode;                           // [R22]
      default:           byte_at = (off < 16'(NSRC)) ? ctl_rd[off[SRC_W-1:0]] : 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      sfr_rdata_o <= 16'h0000;
    else if (sfr_rd_i)
      sfr_rdata_o <= (sfr_size_i == IPMC_ACC_WORD) ?
                     {byte_at({sfr_addr_i[15:1], 1'b1}), byte_at({sfr_addr_i[15:1], 1'b0})} :
                     {8'h00, byte_at(sfr_addr_i)};
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_bad_wdm;
    wdm_imm_wr_i && !wdm_ok;
  endsequence
  sequence s_err_raised;
    operr_req_o && operr_ret_addr_o == $past(instr_addr_i);
  endsequence

  req_set_a:      assert property ((|src_req_i) |=> // [R1]
                                   (request_pending_flag & $past(src_req_i)) == $past(src_req_i))
                  else $error("request pulse did not set flag");
  mask_block_a:   assert property (res_valid |-> !source_block_flag[res_src] && request_pending_flag[res_src]) // [R2]
                  else $error("masked or idle source chosen");
  open_pass_a:    assert property ((|res_pend) && in_service_level == 8'h00 |-> res_valid) // [R3]
                  else $error("unmasked pending source not offered");
  macro_kind_a:   assert property (res_valid && !cpu_ack_i && service_kind_select[res_src]
                                   |=> intr_req_o && intr_kind_o == IPMC_KIND_MACRO) // [R4]
                  else $error("macro service kind not presented");
  swap_kind_a:    assert property (res_valid && !cpu_ack_i && !service_kind_select[res_src] &&
                                   bank_swap_select[res_src] |=> intr_kind_o == IPMC_KIND_SWAP) // [R5]
                  else $error("bank swap kind not presented");
  level_rank_a:   assert property (res_valid && res_pend[3] |-> res_level <= level_field[7:6]) // [R6]
                  else $error("lower level chosen over higher");
  mask_alias_a:   assert property (sfr_wr_i && sfr_size_i == IPMC_ACC_WORD && sfr_addr_i == ADDR_MASK_WORD_LO
                                   |=> ctl_rd[0][CTL_MASK_BIT] == $past(sfr_wdata_i[0])) // [R7] [R8]
                  else $error("mask word write not seen in control byte");
  reset_val_a:    assert property (disable iff (1'b0) reset_i |=> mask_bits == {MASK_UPPER_RESET, MASK_WORD_RESET} &&
                                   in_service_level == IN_SERVICE_RESET && lowest_level_nest_block &&
                                   watchdog_mode == WDOG_MODE_RESET) // [R9] [R14] [R17] [R22]
                  else $error("reset values wrong");
  ack_level_a:    assert property (cpu_ack_i && intr_req_o && intr_kind_o != IPMC_KIND_MACRO
                                   |=> in_service_level[$past(intr_level_o)]) // [R10]
                  else $error("in-service bit not set on ack");
  nmi_mark_a:     assert property (nmi_ack_i |=> in_service_level[NMI_BIT]) // [R11]
                  else $error("non-maskable in-service bit not set");
  ret_clear_a:    assert property (vec_ret_i && in_service_level[NMI_BIT] && in_service_level[0] &&
                                   !nmi_ack_i && !cpu_ack_i |=> !in_service_level[NMI_BIT] &&
                                   in_service_level[0]) // [R12]
                  else $error("return cleared wrong in-service bit");
  brk_keep_a:     assert property ((brk_ret_i || swap_brk_ret_i) && !vec_ret_i && !swap_ret_i &&
                                   !cpu_ack_i && !nmi_ack_i |=> $stable(in_service_level)) // [R13]
                  else $error("break return altered in-service");
  nest_block_a:   assert property (res_valid && in_service_level[3:0] == 4'b1000 &&
                                   lowest_level_nest_block |-> res_level != LEVEL_LOWEST) // [R16]
                  else $error("level 3 nested while blocked");
  bad_wdm_a:      assert property (s_bad_wdm |=> s_err_raised ##0 $stable(watchdog_mode)) // [R19] [R20]
                  else $error("bad watchdog write not trapped");
  bus_wdm_a:      assert property (sfr_wr_i && sfr_addr_i == ADDR_WDOG_MODE && !wdm_imm_wr_i
                                   |=> $stable(watchdog_mode) && !operr_req_o) // [R21]
                  else $error("plain write changed watchdog mode");
  ack_clear_a:    assert property (cpu_ack_i && intr_req_o && !src_req_i[intr_src_o] // [R24]
                                   |=> !request_pending_flag[$past(intr_src_o)])
                  else $error("ack did not clear request flag");

endmodule // ipmc_ctrl

//--- hdl/ipmc_pkg.sv
// constants and types shared by the interrupt priority and mask control block
package ipmc_pkg;

  // ==========================================================================
  // sizes
  localparam int NSRC   = 19;
  localparam int SRC_W  = 5;
  localparam int MASK_W = 24;
  localparam int PC_W   = 20;

  // ==========================================================================
  // register addresses
  localparam logic [15:0] ADDR_IN_SERVICE   = 16'hffa8;
  localparam logic [15:0] ADDR_NEST_CTRL    = 16'hffaa;
  localparam logic [15:0] ADDR_MASK_WORD_LO = 16'hffac;
  localparam logic [15:0] ADDR_MASK_WORD_HI = 16'hffad;
  localparam logic [15:0] ADDR_MASK_UPPER   = 16'hffae;
  localparam logic [15:0] ADDR_WDOG_MODE    = 16'hffc2;
  localparam logic [15:0] ADDR_CTRL_BASE    = 16'hffe0;

  // ==========================================================================
  // control byte fields, in-service non-maskable bit and nesting control bit
  localparam int CTL_REQ_BIT  = 7;
  localparam int CTL_MASK_BIT = 6;
  localparam int CTL_KIND_BIT = 5;
  localparam int CTL_SWAP_BIT = 4;
  localparam int NMI_BIT      = 6;
  localparam int NEST_BIT     = 7;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0]  CTL_RESET        = 8'h43;
  localparam logic [15:0] MASK_WORD_RESET  = 16'hffff;
  localparam logic [7:0]  MASK_UPPER_RESET = 8'hff;
  localparam logic [7:0]  IN_SERVICE_RESET = 8'h00;
  localparam logic [7:0]  NEST_CTRL_RESET  = 8'h80;
  localparam logic [7:0]  WDOG_MODE_RESET  = 8'h00;
  localparam logic [7:0]  WDOG_MODE_WMASK  = 8'h86;
  localparam logic [1:0]  LEVEL_LOWEST     = 2'h3;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {IPMC_ACC_BYTE, IPMC_ACC_WORD, IPMC_ACC_BIT} ipmc_acc_t;
  typedef enum logic [1:0] {IPMC_KIND_VECTOR, IPMC_KIND_SWAP, IPMC_KIND_MACRO} ipmc_kind_t;

endpackage

//--- hdl/ipmc_resolver.sv
// picks the highest-priority pending source allowed by the current in-service level
`timescale 1ns/1ps
module ipmc_resolver
  import ipmc_pkg::*;
(
  input  logic [NSRC-1:0]   pend_i,       // pending and unmasked sources
  input  logic [2*NSRC-1:0] level_i,      // two-bit level per source
  input  logic [3:0]        in_service_i, // maskable in-service levels
  input  logic              nmi_busy_i,   // non-maskable service running
  input  logic              nest_block_i, // lowest-level nesting blocked
  output logic              valid_o,      // a source may be presented
  output logic [SRC_W-1:0]  src_o,        // chosen source
  output logic [1:0]        level_o       // its level
);

  logic       found;
  logic       busy;
  logic [1:0] cur;

  always_comb
  begin
    found   = 1'b0;
    src_o   = '0;
    level_o = LEVEL_LOWEST;
    // lower index wins a tie at the same level
    for (int i = 0; i < NSRC; i++)
    begin
      if (pend_i[i] && (!found || level_i[2*i +: 2] < level_o)) // [R6] [R26]
      begin
        found   = 1'b1;
        src_o   = SRC_W'(i);
        level_o = level_i[2*i +: 2];
      end
    end
    busy = 1'b0;
    cur  = LEVEL_LOWEST;
    for (int l = 3; l >= 0; l--)
    begin
      if (in_service_i[l])
      begin
        busy = 1'b1;
        cur  = 2'(l);
      end
    end
    if (!found || nmi_busy_i)
      valid_o = 1'b0;
    else if (!busy)
      valid_o = 1'b1;
    else
      valid_o = (level_o < cur) ||
                (level_o == LEVEL_LOWEST && cur == LEVEL_LOWEST && !nest_block_i); // [R16]
  end

endmodule // ipmc_resolver

//--- sim/ipmc_cpu_model.sv
// behavioural cpu core that takes maskable requests offered by the block
`timescale 1ns/1ps
module ipmc_cpu_model
(
  input  logic clk_sys_i, // system clock
  input  logic reset_i,   // synchronous reset
  input  logic en_i,      // take offers while high
  input  logic irq_i,     // request offered by the block
  output logic ack_o      // one-cycle take pulse
);
  // ==========================================================================
  // take logic
  // a gap cycle after each take keeps acks at most every other cycle
  // only acks, never touches the in-service register
  always_ff @(posedge clk_sys_i)
    ack_o <= !reset_i && en_i && irq_i && !ack_o;
endmodule // ipmc_cpu_model

//--- sim/tb_top.sv
// self-checking bench for the interrupt priority and mask control block
`timescale 1ns/1ps
module tb_top;
  import ipmc_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, wr = 0, rd = 0, en = 0, ack, irq, nmi, operr;
  logic [15:0] ad = 0, wd = 0, rdata;
  logic [25:0] st = 0;
  logic [7:0]  wdat = 0, wchk = 0;
  logic [19:0] ia = 0, ra;
  logic [2:0]  bt = 0;
  logic [4:0]  src;
  logic [1:0]  lvl;
  ipmc_acc_t   sz = IPMC_ACC_BYTE;
  ipmc_kind_t  kind;
  logic [7:0]  cv[3] = '{8'h01, 8'h11, 8'h21};
  logic [7:0]  iv[3] = '{8'h02, 8'h02, 8'h00};
  ipmc_kind_t  kv[3] = '{IPMC_KIND_VECTOR, IPMC_KIND_SWAP, IPMC_KIND_MACRO};
  int errors = 0, n_checks = 0;

  ipmc_ctrl DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sfr_addr_i(ad), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_size_i(sz), .sfr_bit_i(bt), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
    .src_req_i(st[18:0]), .wdog_req_i(st[19]), .cpu_ack_i(ack), .nmi_ack_i(st[20]),
    .vec_ret_i(st[21]), .swap_ret_i(st[22]), .brk_ret_i(st[23]), .swap_brk_ret_i(st[24]),
    .wdm_imm_wr_i(st[25]), .wdm_imm_data_i(wdat), .wdm_imm_check_i(wchk), .instr_addr_i(ia),
    .intr_req_o(irq), .intr_src_o(src), .intr_level_o(lvl), .intr_kind_o(kind),
    .nmi_req_o(nmi), .operr_req_o(operr), .operr_ret_addr_o(ra));
  ipmc_cpu_model cpu (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .en_i(en), .irq_i(irq), .ack_o(ack));

  always #10 clk_sys_i = ~clk_sys_i;

  // ==========================================================================
  // helpers: every drive lands on a falling edge
  task automatic t(input int n); repeat (n) @(negedge clk_sys_i); endtask
  task c(input logic [19:0] g, input logic [19:0] e);
    n_checks++;
    if (g !== e) begin errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end
  endtask
  task w(input logic [15:0] a, input ipmc_acc_t s, input logic [15:0] d, input logic [2:0] b = 0);
    t(1); ad = a; sz = s; wd = d; bt = b; wr = 1; t(1); wr = 0;
  endtask
  task r(input logic [15:0] a, input logic [15:0] e);
    t(1); ad = a; sz = (a == 16'hffac) ? IPMC_ACC_WORD : IPMC_ACC_BYTE; rd = 1; t(1); rd = 0; t(1); c(rdata, e);
  endtask
  task p(input logic [25:0] v); t(1); st = v; t(1); st = 0; endtask
  task take; en = 1; t(2); en = 0; endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin t(3000); errors++; close_out; end

  initial begin
    t(5); reset_i = 0;
    r(16'hffa8, 0);
    r(16'hffac, 16'hffff); r(16'hffae, 16'h00ff);
    r(16'hffaa, 16'h0080);
    r(16'hffc2, 0);
    r(16'hffe0, 16'h0043);
    $display("reset values done");
    w(16'hffac, IPMC_ACC_WORD, 0); r(16'hffe0, 16'h0003);
    w(16'hffac, IPMC_ACC_BIT, 1, 3'h5); r(16'hffe5, 16'h0043);
    p(26'h20); t(1); c(irq, 0);
    r(16'hffe5, 16'h00c3);
    $display("mask done");
    foreach (cv[i]) begin
      w(16'hffe2, IPMC_ACC_BYTE, cv[i]); w(16'hffe3, IPMC_ACC_BYTE, 16'h02);
      p(26'hc); t(1); c(irq, 1); c(src, 2);
      c(lvl, cv[i][1:0]); c(kind, kv[i]);
      take; r(16'hffe2, cv[i]);
      r(16'hffa8, iv[i]);
      p(26'h200000); r(16'hffa8, 0);
    end
    $display("service kinds done");
    w(16'hffe2, IPMC_ACC_BYTE, 16'h01); p(26'h4); t(1); take;
    p(26'h80000); c(nmi, 1); p(26'h100000); r(16'hffa8, 16'h0042);
    p(26'h800000); p(26'h1000000); r(16'hffa8, 16'h0042);
    p(26'h200000); r(16'hffa8, 16'h0002);
    p(26'h400000); r(16'hffa8, 0);
    w(16'hffe2, IPMC_ACC_BYTE, 16'h03); w(16'hffe3, IPMC_ACC_BYTE, 16'h03);
    p(26'h4); t(1); take; p(26'h8); t(1); c(irq, 0);
    w(16'hffaa, IPMC_ACC_BYTE, 0); t(2); c(irq, 1);
    $display("nesting done");
    wdat = 8'h86; wchk = 8'h79; p(26'h2000000); r(16'hffc2, 16'h0086);
    w(16'hffc2, IPMC_ACC_BYTE, 0); r(16'hffc2, 16'h0086);
    wdat = 8'h80; wchk = 8'h00; ia = 20'h12345; p(26'h2000000);
    c(operr, 1); c(ra, 20'h12345); t(1); c(operr, 0);
    r(16'hffc2, 16'h0086);
    $display("watchdog mode done");
    // the operand error handler reinitialises the system instead of break-returning
    reset_i = 1; t(2); reset_i = 0; c(irq, 0);
    r(16'hffa8, 0); r(16'hffac, 16'hffff);
    r(16'hffaa, 16'h0080); r(16'hffc2, 0);
    $display("reinit done");
    close_out;
  end
endmodule // tb_top
